// File: design/sps_shifter.sv
`timescale 1ns/1ns
// Behaviour
// (R1) Eight stages form a chain fed serially at the first stage and all eight are shown at once.
// (R2) The first stage loads the AND of the two serial inputs, so a low on either shifts in zero.
// (R3) With one serial input held high the other alone decides the bit entered next.
// (R4) Stages change only on a rising edge of the shift clock, never on its falling edge.
// (R5) A low on the clear input forces every stage low at once, with no clock and any data.
// (R6) At each rising edge with clear released each later stage takes its predecessor's value.
// (R7) With clear released and no rising edge all stages keep their values.
// (R8) Serial inputs may change at any clock level and only their value at the rising edge counts.
module sps_shifter #(
  parameter int STAGES = sps_pkg::STAGES,
  parameter int FIFO_DEPTH = sps_pkg::FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clear_n,
  input wire logic shift_clk,
  input wire logic serial_a,
  input wire logic serial_b,
  output logic [STAGES-1:0] stage_out,
  output logic first_stage_out,
  output logic last_stage_out,
  output logic word_valid,
  output logic [STAGES-1:0] word_data,
  input wire logic word_ready,
  output logic shift_ready,
  output logic overrun
);
  // The clear constant is one fixed-width word, so the chain length cannot move
  if (STAGES != sps_pkg::STAGES) begin : g_bad_stages
    $error("sps_shifter: the stage chain is fixed at eight");
  end
  // The buffer wraps its pointers, so only powers of two are served
  if (FIFO_DEPTH < 2 || (1 << $clog2(FIFO_DEPTH)) != FIFO_DEPTH) begin : g_bad_depth
    $error("sps_shifter: FIFO_DEPTH must be a power of two of at least 2");
  end

  logic [STAGES-1:0] stages_q;
  logic shift_clk_q;
  logic shift_rise;
  logic shifted_q;
  logic overrun_q;

  sps_stream_if #(.W(STAGES)) push_if ();
  sps_stream_if #(.W(STAGES)) pop_if ();

  // Shift clock is a sampled pin; only its low-to-high change moves data
  assign shift_rise = shift_clk & ~shift_clk_q; // R4

  always_ff @(posedge core_clk) begin
    if (rst) begin
      shift_clk_q <= 1'b1;
    end else begin
      shift_clk_q <= shift_clk;
    end
  end

  // Clear is asynchronous and overrides clock, reset and data
  always_ff @(posedge core_clk or negedge clear_n) begin
    if (!clear_n) begin
      stages_q <= sps_pkg::STAGE_CLEAR; // R5
    end else if (rst) begin
      stages_q <= sps_pkg::STAGE_CLEAR;
    end else if (shift_rise) begin // R4 R7
      // Inputs are taken at the sampled edge, later changes have no effect
      stages_q <= {stages_q[STAGES-2:0], serial_a & serial_b}; // R1 R2 R3 R6 R8
    end
  end

  assign stage_out = stages_q; // R1
  assign first_stage_out = stages_q[0];
  assign last_stage_out = stages_q[STAGES-1];

  // Each shifted word is offered to the buffer one cycle after the edge
  always_ff @(posedge core_clk or negedge clear_n) begin
    if (!clear_n) begin
      shifted_q <= sps_pkg::FLAG_CLEAR;
    end else if (rst) begin
      shifted_q <= sps_pkg::FLAG_CLEAR;
    end else begin
      shifted_q <= shift_rise;
    end
  end

  assign push_if.valid = shifted_q;
  assign push_if.data = stages_q;

  // A word the full buffer could not take is lost; the flag tells the consumer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      overrun_q <= sps_pkg::FLAG_CLEAR;
    end else if (shifted_q && !push_if.ready) begin
      overrun_q <= 1'b1;
    end
  end

  sps_fifo #(
    .W(STAGES),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .in_s(push_if),
    .out_s(pop_if)
  );

  assign pop_if.ready = word_ready;
  assign word_valid = pop_if.valid;
  assign word_data = pop_if.data;
  assign shift_ready = push_if.ready;
  assign overrun = overrun_q;
endmodule

// File: shared/sps_pkg.sv
package sps_pkg;
  localparam int STAGES = 8;
  localparam int FIFO_DEPTH = 8;
  localparam logic [STAGES-1:0] STAGE_CLEAR = 8'h00;
  localparam logic FLAG_CLEAR = 1'b0;
endpackage

// File: shared/sps_stream_if.sv
`timescale 1ns/1ns
interface sps_stream_if #(
  parameter int W = 8
);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface

// File: design/sps_fifo.sv
`timescale 1ns/1ns
module sps_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  sps_stream_if.sink in_s,
  sps_stream_if.source out_s
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("sps_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic not_full_q;
  logic head_valid_q;
  logic [W-1:0] head_q;
  logic push;
  logic load;

  // Ready and valid both come from flops so the top can drive its pins directly
  assign push = in_s.valid & not_full_q;
  assign load = (cnt_q != '0) & (~head_valid_q | out_s.ready);
  assign cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
  assign in_s.ready = not_full_q;
  assign out_s.valid = head_valid_q;
  assign out_s.data = head_q;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_q] <= in_s.data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      not_full_q <= 1'b1;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (load) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_d;
      not_full_q <= cnt_d < (AW+1)'(DEPTH);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      head_valid_q <= 1'b0;
      head_q <= '0;
    end else if (load) begin
      head_valid_q <= 1'b1;
      head_q <= mem[rd_q];
    end else if (out_s.ready) begin
      head_valid_q <= 1'b0;
    end
  end
endmodule

// File: tb/sps_monitor.sv
`timescale 1ns/1ns
module sps_monitor #(
  parameter int STAGES = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clear_n,
  input wire logic shift_clk,
  input wire logic serial_a,
  input wire logic serial_b,
  input wire logic [STAGES-1:0] stage_out,
  input wire logic first_stage_out,
  input wire logic last_stage_out,
  input wire logic word_valid,
  input wire logic [STAGES-1:0] word_data,
  input wire logic word_ready,
  input wire logic shift_ready,
  input wire logic overrun
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_clear_zero: assert property (!clear_n |-> stage_out == '0)
    else $error("stages not cleared");
  a_shift_in: assert property ($rose(shift_clk) && clear_n && !$past(rst) |=>
    !clear_n || stage_out == {$past(stage_out[STAGES-2:0]), $past(serial_a) & $past(serial_b)})
    else $error("bad shift");
  a_hold_still: assert property (clear_n && !$rose(shift_clk) |=>
    !clear_n || $stable(stage_out)) else $error("stages moved");
  a_stage_ends: assert property (first_stage_out == stage_out[0] &&
    last_stage_out == stage_out[STAGES-1]) else $error("end taps wrong");
  a_valid_hold: assert property (word_valid && !word_ready |=> word_valid)
    else $error("word lost");
  a_data_hold: assert property (word_valid && !word_ready |=> $stable(word_data))
    else $error("word changed while offered");
  a_overrun_stick: assert property (overrun |=> overrun) else $error("overrun lost");
  a_reset_vals: assert property ($fell(rst) |-> stage_out == '0 && !word_valid &&
    shift_ready && !overrun) else $error("bad reset state");
  a_full_head: assert property (!shift_ready |-> word_valid) else $error("full but empty");
endmodule
bind sps_shifter sps_monitor #(.STAGES(STAGES)) u_mon (.*);

// File: tb/sps_upstream.sv
`timescale 1ns/1ns
module sps_upstream (
  input wire logic go,
  input wire logic [1:0] ab,
  output logic shift_clk,
  output logic serial_a,
  output logic serial_b
);
  // Data may move while the clock is high; only the edge sample counts
  assign {shift_clk, serial_a, serial_b} = {go, ab};
endmodule

// File: tb/serial_in_parallel_out_shifter_test.sv
`timescale 1ns/1ns
module serial_in_parallel_out_shifter_test;
  logic core_clk = 0, rst = 1, clear_n = 1, go = 0, word_ready = 1;
  logic [1:0] ab = 2'h0;
  logic shift_clk, serial_a, serial_b, word_valid, shift_ready, overrun, fo, lo;
  logic [7:0] so, wd, e;
  int num_errors = 0, checked = 0, n;
  always #4 core_clk = ~core_clk;
  sps_upstream i_up (.go(go), .ab(ab), .shift_clk(shift_clk), .serial_a(serial_a),
    .serial_b(serial_b));
  sps_shifter i_dut (.core_clk(core_clk), .rst(rst), .clear_n(clear_n),
    .shift_clk(shift_clk), .serial_a(serial_a), .serial_b(serial_b), .stage_out(so),
    .first_stage_out(fo), .last_stage_out(lo), .word_valid(word_valid), .word_data(wd),
    .word_ready(word_ready), .shift_ready(shift_ready), .overrun(overrun));
  task chk(input string s, input logic [7:0] x, y);
    checked++;
    if (x !== y) begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", s, x, y);
    end
  endtask
  task sh(input logic [1:0] v);
    @(negedge core_clk);
    go = 1;
    ab = v;
    e = {e[6:0], &v};
    @(negedge core_clk);
    go = 0;
    ab = ~v;
    @(negedge core_clk);
    chk("stage", e, so);
  endtask
  task finish_test;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task test_gate;
    for (int i = 0; i < 4; i++) sh(i[1:0]);
    $display("gate test done");
  endtask
  task test_fill;
    logic [7:0] pat;
    pat = 8'ha5;
    for (int i = 7; i >= 0; i--) sh({2{pat[i]}});
    chk("fill", 8'ha5, so);
    chk("last", {7'h00, pat[7]}, {7'h00, lo});
    chk("first", {7'h00, pat[0]}, {7'h00, fo});
    $display("fill test done");
  endtask
  task test_clear;
    @(negedge core_clk);
    clear_n = 0;
    go = 1;
    ab = 2'h3;
    #1 chk("clear", 8'h00, so);
    @(negedge core_clk);
    chk("clear held", 8'h00, so);
    go = 0;
    clear_n = 1;
    e = 8'h00;
    @(negedge core_clk);
    chk("clear released", 8'h00, so);
    $display("clear test done");
  endtask
  task test_buffer;
    logic [7:0] q [10];
    n = 0;
    word_ready = 0;
    for (int i = 0; i < 10; i++) begin
      sh(2'h3);
      q[i] = e;
    end
    chk("overrun", 8'h01, {7'h00, overrun});
    chk("ready", 8'h00, {7'h00, shift_ready});
    // A word on offer is judged in the cycle before the edge that takes it
    for (int i = 0; i < 30; i++) begin
      if (word_valid === 1'b1) begin
        chk("word", q[n], wd);
        n++;
      end
      word_ready = 1;
      @(negedge core_clk);
    end
    chk("count", 8'h09, n[7:0]);
    chk("room", 8'h01, {7'h00, shift_ready});
    $display("buffer test done");
  endtask
  task test_reset;
    @(negedge core_clk);
    go = 1;
    ab = 2'h3;
    rst = 1;
    repeat (2) @(negedge core_clk);
    rst = 0;
    repeat (2) @(negedge core_clk);
    chk("reset stage", 8'h00, so);
    chk("reset flags", 8'h01, {6'h00, overrun, shift_ready});
    chk("reset valid", 8'h00, {7'h00, word_valid});
    go = 0;
    e = 8'h00;
    sh(2'h3);
    $display("reset test done");
  endtask
  initial begin
    e = 8'h00;
    repeat (2) @(negedge core_clk);
    rst = 0;
    test_gate();
    test_fill();
    test_clear();
    test_buffer();
    test_reset();
    finish_test();
  end
endmodule
